// ### rtl/capcom_unit.sv
// Function
// - Thirty-two channels; one-cycle resolution, eight cycles when staggered.
// - Two 16-bit reloadable timers per array, four in total.
// - Timer clock: prescaled system clock or general timer six overflow.
// - First timer of each array may count external input rising edges.
// - Sixteen channels per array; each picks a timer and capture/compare.
// - Twelve second-array channels own a pin for capture or output.
// - Compare mode 0: interrupt on every match.
// - Compare mode 1: pin toggles on every match.
// - Compare mode 2: at most one interrupt per timer period.
// - Compare mode 3: pin set on match, cleared on overflow.
// - Double register mode: two channels toggle one shared pin.
// - Single event option disables the channel after its first event.
// - Capture latches the allocated timer on a pin event.
// - Each capture raises that channel's own interrupt request.
// - Capture edge selectable: rising, falling or both.
// - Compare channels checked at every count; match runs mode action.
`include "capcom_defines.svh"

module capcom_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] cc_pin_in,
  input  wire logic [1:0]  ext_count_in,
  input  wire logic        gp2_timer_six_ovf,
  output logic      [11:0] cc_pin_out,
  output logic      [11:0] cc_pin_oe,
  output logic             irq
);

  typedef struct packed {
    logic [31:0][15:0]             val;
    capcom_pkg::chcfg_t [31:0]     cfg;
    logic [3:0][15:0]              rel;
    capcom_pkg::tcfg_t [3:0]       tcfg;
    logic [31:0]                   done;
    logic [31:0]                   st;
    logic [31:0]                   en;
    logic                          stag;
    logic [4:0]                    pre;
    logic [11:0]                   s1;
    logic [11:0]                   s2;
    logic [11:0]                   s3;
    logic [1:0]                    e1;
    logic [1:0]                    e2;
    logic [1:0]                    e3;
    logic [11:0]                   pin;
    logic [11:0]                   oe;
    logic                          irq;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } state_t;

  state_t      s_q;
  state_t      s_d;

  timer_if     tif[4] ();

  logic [3:0]  tick;
  logic [3:0]  ld;
  logic [3:0][15:0] cnt;
  logic [3:0]  upd;
  logic [3:0]  ovf;
  logic        wr;
  logic        hit;
  logic [31:0] clr;
  logic [31:0] ev;
  logic [31:0] cap_ev;
  logic [31:0] cmp_ev;
  logic [4:0]  mask;
  logic        src;
  logic [1:0]  t;
  logic        rise;
  logic        fall;
  logic        m;
  int          p;

  for (genvar g = 0; g < 4; g++)
  begin : g_tmr
    assign tif[g].tick   = tick[g];
    assign tif[g].ld     = ld[g];
    assign tif[g].ld_val = pwdata[15:0];
    assign tif[g].rel    = s_q.rel[g];
    assign cnt[g]        = tif[g].cnt;
    assign upd[g]        = tif[g].upd;
    assign ovf[g]        = tif[g].ovf;
    capcom_timer #(.W(16)) u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif[g])
    );
  end

  always_comb
  begin
    s_d    = s_q;
    clr    = 32'h0;
    ev     = 32'h0;
    cap_ev = 32'h0;
    cmp_ev = 32'h0;
    tick   = 4'h0;
    ld     = 4'h0;
    hit    = 1'b0;
    mask   = 5'h0;
    src    = 1'b0;
    t      = 2'h0;
    rise   = 1'b0;
    fall   = 1'b0;
    m      = 1'b0;
    p      = 0;
    wr     = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;

    // Pin and count inputs cross in through two flops
    s_d.s1  = cc_pin_in;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    s_d.e1  = ext_count_in;
    s_d.e2  = s_q.e1;
    s_d.e3  = s_q.e2;
    s_d.pre = s_q.pre + 5'h01;

    for (int i = 0; i < 4; i++)
    begin
      if (s_q.tcfg[i].sel == `SEL_GP2)
        src = gp2_timer_six_ovf;
      else if (s_q.tcfg[i].sel == `SEL_EXT)
        src = (i % 2 == 0) && s_q.e2[i/2] && !s_q.e3[i/2];
      else
      begin
        mask = 5'((32'h1 << s_q.tcfg[i].sel) - 32'h1);
        src  = (s_q.pre & mask) == mask;
        // Staggered: internal clock ticks at most once in eight cycles
        if (s_q.stag && s_q.pre[2:0] != `STAG_SLOT)
          src = 1'b0;
      end
      tick[i] = s_q.tcfg[i].run & src;
    end

    // APB: decode in setup, answer from flops in the access cycle
    s_d.pready  = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0;
    if (psel && !penable)
    begin
      if (paddr[1:0] != 2'h0 || paddr >= `CC_END_OFS)
        s_d.pslverr = 1'b1;
      else if (paddr < `CC_CFG_BASE)
        s_d.prdata = {16'h0, s_q.val[paddr[6:2]]};
      else if (paddr < `CC_TCTL_BASE)
        s_d.prdata = {25'h0, s_q.cfg[paddr[6:2]]};
      else if (paddr < `CC_TCNT_BASE)
        s_d.prdata = {28'h0, s_q.tcfg[paddr[3:2]]};
      else if (paddr < `CC_TREL_BASE)
        s_d.prdata = {16'h0, cnt[paddr[3:2]]};
      else if (paddr < `CC_STAT_OFS)
        s_d.prdata = {16'h0, s_q.rel[paddr[3:2]]};
      else if (paddr == `CC_STAT_OFS)
        s_d.prdata = s_q.st;
      else if (paddr == `CC_IEN_OFS)
        s_d.prdata = s_q.en;
      else if (paddr == `CC_GCTL_OFS)
        s_d.prdata = {31'h0, s_q.stag};
    end

    if (wr)
    begin
      if (paddr < `CC_CFG_BASE)
        s_d.val[paddr[6:2]] = pwdata[15:0];
      else if (paddr < `CC_TCTL_BASE)
        s_d.cfg[paddr[6:2]] =
          capcom_pkg::chcfg_t'(pwdata[`CFG_SINGLE_BIT:0]);
      else if (paddr < `CC_TCNT_BASE)
        s_d.tcfg[paddr[3:2]] = pwdata[`TCTL_SEL_MSB:0];
      else if (paddr < `CC_TREL_BASE)
        ld[paddr[3:2]] = 1'b1;
      else if (paddr < `CC_STAT_OFS)
        s_d.rel[paddr[3:2]] = pwdata[15:0];
      else if (paddr == `CC_CLR_OFS)
        clr = pwdata;
      else if (paddr == `CC_IEN_OFS)
        s_d.en = pwdata;
      else if (paddr == `CC_GCTL_OFS)
        s_d.stag = pwdata[`GCTL_STAG_BIT];
    end

    for (int c = 0; c < 32; c++)
    begin
      t = {c[4], s_q.cfg[c].tsel};
      // Matches count only on the cycle after the timer moved
      m = upd[t] && cnt[t] == s_q.val[c];
      if (ovf[t])
        s_d.done[c] = 1'b0;
      // Only second-array channels 16..27 have a pin
      hit = c >= 16 && c < 28;
      p   = hit ? c - 16 : 0;
      rise = hit && s_q.s2[p] && !s_q.s3[p];
      fall = hit && !s_q.s2[p] && s_q.s3[p];
      unique case (s_q.cfg[c].mode)
        capcom_pkg::M_CAP:
        begin
          cap_ev[c] = (s_q.cfg[c].edge_sel[0] && rise) ||
                      (s_q.cfg[c].edge_sel[1] && fall);
          if (cap_ev[c])
            s_d.val[c] = cnt[t];
        end
        capcom_pkg::M_CMP0:
          cmp_ev[c] = m;
        capcom_pkg::M_CMP1:
        begin
          cmp_ev[c] = m;
          if (m && hit)
            s_d.pin[p] = ~s_d.pin[p];
        end
        capcom_pkg::M_CMP2:
          cmp_ev[c] = m && !s_q.done[c];
        capcom_pkg::M_CMP3:
        begin
          cmp_ev[c] = m && !s_q.done[c];
          if (hit && cmp_ev[c])
            s_d.pin[p] = 1'b1;
          else if (hit && ovf[t])
            s_d.pin[p] = 1'b0;
        end
        capcom_pkg::M_DBL:
        begin
          cmp_ev[c] = m;
          if (m && c >= 16)
            s_d.pin[c % 8] = ~s_d.pin[c % 8];
        end
        default:
          cmp_ev[c] = 1'b0;
      endcase
      if (cmp_ev[c])
        s_d.done[c] = 1'b1;
      if ((cmp_ev[c] || cap_ev[c]) && s_q.cfg[c].single)
        s_d.cfg[c].mode = capcom_pkg::M_OFF;
    end
    ev = cap_ev | cmp_ev;

    for (int q = 0; q < 12; q++)
    begin
      s_d.oe[q] = s_d.cfg[16+q].mode inside
        {capcom_pkg::M_CMP1, capcom_pkg::M_CMP3, capcom_pkg::M_DBL};
      if (q < 8 && s_d.cfg[24+q].mode == capcom_pkg::M_DBL)
        s_d.oe[q] = 1'b1;
    end

    // A new event wins over a clear in the same cycle
    s_d.st  = (s_q.st & ~clr) | ev;
    s_d.irq = |(s_d.st & s_d.en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q      <= '0;
      s_q.cfg  <= {32{`CFG_RST}};
      s_q.tcfg <= {4{`TCTL_RST}};
    end
    else
      s_q <= s_d;
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign cc_pin_out = s_q.pin;
  assign cc_pin_oe  = s_q.oe;
  assign irq        = s_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready || (psel && !penable);
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB answer not one-cycle ready");

  property p_capture;
    cap_ev[20] |=> s_q.st[20] && s_q.val[20] == $past(cnt[{1'b1,
      s_q.cfg[20].tsel}]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not latch timer");

  property p_cap_edge;
    s_q.cfg[20].mode == capcom_pkg::M_CAP &&
    s_q.cfg[20].edge_sel == 2'h1 && !s_q.s2[4] && s_q.s3[4]
    |-> !cap_ev[20];
  endproperty
  a_cap_edge: assert property (p_cap_edge)
    else $error("falling edge captured in rising mode");

  property p_no_pin;
    cap_ev[15:0] == 16'h0 && cap_ev[31:28] == 4'h0;
  endproperty
  a_no_pin: assert property (p_no_pin)
    else $error("capture on a channel without pin");

  property p_mode1;
    s_q.cfg[16].mode == capcom_pkg::M_CMP1 && cmp_ev[16] &&
    s_q.cfg[24].mode != capcom_pkg::M_DBL
    |=> cc_pin_out[0] != $past(cc_pin_out[0]);
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("mode 1 pin did not toggle");

  property p_mode2;
    s_q.cfg[1].mode == capcom_pkg::M_CMP2 && s_q.done[1] &&
    !ovf[{1'b0, s_q.cfg[1].tsel}] |-> !cmp_ev[1];
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("second mode 2 event in one period");

  property p_mode3;
    s_q.cfg[17].mode == capcom_pkg::M_CMP3 && cmp_ev[17]
    |=> cc_pin_out[1] ##1 1'b1;
  endproperty
  a_mode3: assert property (p_mode3)
    else $error("mode 3 pin not set on match");

  property p_mode3_clr;
    s_q.cfg[17].mode == capcom_pkg::M_CMP3 && !cmp_ev[17] &&
    ovf[{1'b1, s_q.cfg[17].tsel}] |=> !cc_pin_out[1];
  endproperty
  a_mode3_clr: assert property (p_mode3_clr)
    else $error("mode 3 pin not cleared on overflow");

  property p_single;
    s_q.cfg[19].single && (cmp_ev[19] || cap_ev[19])
    |=> s_q.cfg[19].mode == capcom_pkg::M_OFF;
  endproperty
  a_single: assert property (p_single)
    else $error("single event channel stayed active");

  property p_irq;
    cmp_ev[1] && s_q.en[1] && !wr |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise irq");

  c_capture: cover property (cap_ev[20]);
  c_mode3: cover property (cmp_ev[17] ##[1:200] !cc_pin_out[1]);
  c_dbl: cover property (s_q.cfg[24].mode == capcom_pkg::M_DBL &&
    cmp_ev[24]);

endmodule

// ### rtl/capcom_defines.svh
`ifndef CAPCOM_DEFINES_SVH
`define CAPCOM_DEFINES_SVH

// Byte offsets on the APB window (paddr[9:0])
`define CC_VAL_BASE    10'h000
`define CC_CFG_BASE    10'h080
`define CC_TCTL_BASE   10'h100
`define CC_TCNT_BASE   10'h110
`define CC_TREL_BASE   10'h120
`define CC_STAT_OFS    10'h130
`define CC_CLR_OFS     10'h134
`define CC_IEN_OFS     10'h138
`define CC_GCTL_OFS    10'h13c
`define CC_END_OFS     10'h140

// Channel configuration fields
`define CFG_MODE_LSB   0
`define CFG_MODE_MSB   2
`define CFG_TSEL_BIT   3
`define CFG_EDGE_LSB   4
`define CFG_EDGE_MSB   5
`define CFG_SINGLE_BIT 6

// Timer control fields and clock selections
`define TCTL_RUN_BIT   0
`define TCTL_SEL_LSB   1
`define TCTL_SEL_MSB   3
`define SEL_GP2        3'h6
`define SEL_EXT        3'h7
`define GCTL_STAG_BIT  0

// Staggered mode: one slot out of eight
`define STAG_SLOT      3'h7

// Reset values
`define CFG_RST        7'h00
`define TCTL_RST       4'h0
`define TIMER_RST      16'h0000

`endif

// ### rtl/capcom_pkg.sv
package capcom_pkg;

  typedef enum logic [2:0] {
    M_OFF  = 3'h0,
    M_CAP  = 3'h1,
    M_DBL  = 3'h2,
    M_CMP0 = 3'h4,
    M_CMP1 = 3'h5,
    M_CMP2 = 3'h6,
    M_CMP3 = 3'h7
  } mode_t;

  typedef struct packed {
    logic       single;
    logic [1:0] edge_sel;
    logic       tsel;
    mode_t      mode;
  } chcfg_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       run;
  } tcfg_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        upd;
    logic        ovf;
  } tmr_state_t;

endpackage

// ### rtl/timer_if.sv
interface timer_if;
  logic        tick;
  logic        ld;
  logic [15:0] ld_val;
  logic [15:0] rel;
  logic [15:0] cnt;
  logic        upd;
  logic        ovf;

  modport ctrl (output tick, ld, ld_val, rel, input cnt, upd, ovf);
  modport tmr  (input tick, ld, ld_val, rel, output cnt, upd, ovf);
endinterface

// ### rtl/capcom_timer.sv
`include "capcom_defines.svh"

module capcom_timer #(
  parameter int W = 16
) (
  input  wire logic pclk,
  input  wire logic presetn,
  timer_if.tmr      tif
);

  if (W != 16)
  begin : g_bad_width
    $error("capcom_timer supports W = 16 only");
  end

  capcom_pkg::tmr_state_t s_q;
  capcom_pkg::tmr_state_t s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.upd = 1'b0;
    s_d.ovf = 1'b0;
    if (tif.ld)
      s_d.cnt = tif.ld_val;
    else if (tif.tick)
    begin
      s_d.upd = 1'b1;
      if (&s_q.cnt)
      begin
        s_d.cnt = tif.rel;
        s_d.ovf = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{cnt: `TIMER_RST, upd: 1'b0, ovf: 1'b0};
    else
      s_q <= s_d;
  end

  assign tif.cnt = s_q.cnt;
  assign tif.upd = s_q.upd;
  assign tif.ovf = s_q.ovf;

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    tif.tick && !tif.ld && (&s_q.cnt) |=>
      s_q.ovf && s_q.cnt == $past(tif.rel);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer did not reload on overflow");

endmodule

// ### dv/pin_world.sv
module pin_world (
  input  wire logic        pclk,
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  output logic      [11:0] pin_in,
  output logic      [1:0]  ext_in,
  output logic             six_ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] drv = 12'h000;
  initial ext_in = 2'h0;
  initial six_ovf = 1'b0;
  // A driven pad reads back its own level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  task automatic set_pin(input int n, input logic v);
    @(posedge pclk);
    drv[n] <= v;
  endtask
  // High for two cycles, then low for three, so the synchroniser sees every edge
  task automatic ext_pulse(input int n);
    @(posedge pclk);
    ext_in[n] <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_in[n] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic six_pulse();
    @(posedge pclk);
    six_ovf <= 1'b1;
    @(posedge pclk);
    six_ovf <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ### dv/tb.sv
`include "capcom_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] pin_in;
  logic [1:0]  ext_in;
  logic        six_ovf;
  logic [11:0] pin_out;
  logic [11:0] pin_oe;
  logic        irq;
  logic [11:0] po_q = 12'h000;
  logic [31:0] r;
  logic        e;
  int          rc[4] = '{0, 0, 0, 0};
  int          bs[4];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          t1;
  always #10 pclk = ~pclk;
  capcom_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cc_pin_in(pin_in), .ext_count_in(ext_in),
    .gp2_timer_six_ovf(six_ovf), .cc_pin_out(pin_out),
    .cc_pin_oe(pin_oe), .irq(irq));
  pin_world pw (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .ext_in(ext_in), .six_ovf(six_ovf));
  always @(posedge pclk)
  begin
    po_q <= pin_out;
    for (int i = 0; i < 4; i++)
      if (pin_out[i] & ~po_q[i])
        rc[i] <= rc[i] + 1;
  end
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] b, input int i, input logic [31:0] d);
    apb(1'b1, 10'(b + 4 * i), d);
  endtask
  task automatic rd(input logic [9:0] b, input int i);
    apb(1'b0, 10'(b + 4 * i), 32'h0);
  endtask
  function automatic logic [31:0] cf(capcom_pkg::mode_t m, logic ts,
                                     logic [1:0] ed, logic sg);
    return {25'h0, sg, ed, ts, m};
  endfunction
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CC_CFG_BASE, 5);
    check("cfg reset", r, 32'h0);
    rd(`CC_STAT_OFS, 0);
    check("stat reset", r, 32'h0);
    apb(1'b0, `CC_END_OFS, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    // Pin-less channel 1 on timer b of the first array
    wr(`CC_TREL_BASE, 1, 32'hfff0);
    wr(`CC_TCNT_BASE, 1, 32'hfff0);
    wr(`CC_VAL_BASE, 1, 32'hfff4);
    wr(`CC_CFG_BASE, 1, cf(capcom_pkg::M_CMP0, 1'b1, 2'h0, 1'b0));
    wr(`CC_IEN_OFS, 0, 32'h2);
    wr(`CC_TCTL_BASE, 1, 32'h1);
    repeat (40) @(posedge pclk);
    check("cmp0 irq", {31'h0, irq}, 32'h1);
    check("no pin oe", {20'h0, pin_oe}, 32'h0);
    wr(`CC_TCTL_BASE, 1, 32'h0);
    wr(`CC_CLR_OFS, 0, 32'h2);
    rd(`CC_STAT_OFS, 0);
    check("cleared", r & 32'h2, 32'h0);
    check("irq low", {31'h0, irq}, 32'h0);
    // Stopped timer keeps its reloaded count
    rd(`CC_TCNT_BASE, 1);
    t1 = int'(r[15:0]);
    check("reload", {31'h0, 1'(t1 >= 32'hfff0)}, 32'h1);
    wr(`CC_TCTL_BASE, 1, 32'h1);
    repeat (40) @(posedge pclk);
    rd(`CC_STAT_OFS, 0);
    check("cmp0 again", r & 32'h2, 32'h2);
    // Mode 2: a rewound count may not fire twice in one period
    wr(`CC_TCTL_BASE, 1, 32'h0);
    wr(`CC_TCNT_BASE, 1, 32'hfffe);
    wr(`CC_CFG_BASE, 1, cf(capcom_pkg::M_CMP2, 1'b1, 2'h0, 1'b0));
    wr(`CC_CLR_OFS, 0, 32'h2);
    wr(`CC_TCTL_BASE, 1, 32'h1);
    repeat (8) @(posedge pclk);
    wr(`CC_TCTL_BASE, 1, 32'h0);
    rd(`CC_STAT_OFS, 0);
    check("cmp2 first", r & 32'h2, 32'h2);
    wr(`CC_CLR_OFS, 0, 32'h2);
    wr(`CC_TCNT_BASE, 1, 32'hfff2);
    wr(`CC_TCTL_BASE, 1, 32'h1);
    repeat (6) @(posedge pclk);
    rd(`CC_STAT_OFS, 0);
    check("cmp2 once", r & 32'h2, 32'h0);
    repeat (20) @(posedge pclk);
    rd(`CC_STAT_OFS, 0);
    check("cmp2 next", r & 32'h2, 32'h2);
    wr(`CC_CFG_BASE, 1, 32'h0);
    // Second array: toggle, set/reset, double pair, single event
    wr(`CC_TREL_BASE, 2, 32'hfff0);
    wr(`CC_TCNT_BASE, 2, 32'hfff0);
    for (int c = 16; c < 20; c++)
      wr(`CC_VAL_BASE, c, 32'hfff8);
    wr(`CC_VAL_BASE, 18, 32'hfff2);
    wr(`CC_VAL_BASE, 26, 32'hfff9);
    wr(`CC_CFG_BASE, 16, cf(capcom_pkg::M_CMP1, 1'b0, 2'h0, 1'b0));
    wr(`CC_CFG_BASE, 17, cf(capcom_pkg::M_CMP3, 1'b0, 2'h0, 1'b0));
    wr(`CC_CFG_BASE, 18, cf(capcom_pkg::M_DBL, 1'b0, 2'h0, 1'b0));
    wr(`CC_CFG_BASE, 26, cf(capcom_pkg::M_DBL, 1'b0, 2'h0, 1'b0));
    wr(`CC_CFG_BASE, 19, cf(capcom_pkg::M_CMP1, 1'b0, 2'h0, 1'b1));
    bs = rc;
    wr(`CC_TCTL_BASE, 2, 32'h1);
    repeat (160) @(posedge pclk);
    check("oe pins", {20'h0, pin_oe[2:0]}, 32'h7);
    // Ten matches of channels 16, 17, 18 and 26 fall inside the window
    check("mode1", 32'(rc[0] - bs[0]), 32'h5);
    check("mode3", 32'(rc[1] - bs[1]), 32'ha);
    check("double", 32'(rc[2] - bs[2]), 32'ha);
    check("single", 32'(rc[3] - bs[3]), 32'h1);
    rd(`CC_CFG_BASE, 19);
    check("single off", r & 32'h7, 32'h0);
    wr(`CC_TCTL_BASE, 2, 32'h0);
    // Capture on channel 20, pin 4, timer b held still
    wr(`CC_TCNT_BASE, 3, 32'h1234);
    wr(`CC_CFG_BASE, 20, cf(capcom_pkg::M_CAP, 1'b1, 2'h1, 1'b0));
    wr(`CC_IEN_OFS, 0, 32'h0010_0000);
    pw.set_pin(4, 1'b1);
    repeat (8) @(posedge pclk);
    check("cap irq", {31'h0, irq}, 32'h1);
    rd(`CC_VAL_BASE, 20);
    check("cap val", r, 32'h1234);
    // Earlier compare events are still sticky: clear them all
    wr(`CC_CLR_OFS, 0, 32'hffff_ffff);
    wr(`CC_TCNT_BASE, 3, 32'h5678);
    pw.set_pin(4, 1'b0);
    repeat (8) @(posedge pclk);
    rd(`CC_STAT_OFS, 0);
    check("fall ignored", r, 32'h0);
    wr(`CC_CFG_BASE, 20, cf(capcom_pkg::M_CAP, 1'b1, 2'h3, 1'b0));
    pw.set_pin(4, 1'b1);
    repeat (8) @(posedge pclk);
    rd(`CC_VAL_BASE, 20);
    check("both edges", r, 32'h5678);
    // External and general-timer count sources
    wr(`CC_TCNT_BASE, 0, 32'h0);
    wr(`CC_TCTL_BASE, 0, {28'h0, `SEL_EXT, 1'b1});
    // Timer 1 still runs: change its source before loading it
    wr(`CC_TCTL_BASE, 1, {28'h0, `SEL_GP2, 1'b1});
    wr(`CC_TCNT_BASE, 1, 32'h0);
    for (int k = 0; k < 3; k++)
      pw.ext_pulse(0);
    for (int k = 0; k < 4; k++)
      pw.six_pulse();
    rd(`CC_TCNT_BASE, 0);
    check("ext count", r, 32'h3);
    rd(`CC_TCNT_BASE, 1);
    check("six count", r, 32'h4);
    // Staggered: one tick per eight cycles over an 83-cycle gap
    wr(`CC_GCTL_OFS, 0, 32'h1);
    wr(`CC_TCTL_BASE, 3, 32'h1);
    rd(`CC_TCNT_BASE, 3);
    t1 = int'(r[15:0]);
    repeat (80) @(posedge pclk);
    rd(`CC_TCNT_BASE, 3);
    check("stagger", 32'((int'(r[15:0]) - t1) / 2), 32'h5);
    test_done();
  end
endmodule
